// ### rtl/ths_regs.sv
// Hysteresis, tree-test and temperature offset registers with the per-channel fan loop.
// Assumes an APB master on pclk; temperatures arrive synchronous to pclk as unsigned degrees C.
//
// Behaviour
// - The local hysteresis is the low nibble of the combined register and drives the local loop.
// - The first remote hysteresis is the high nibble of the combined register and drives its loop.
// - A separate read-write register holds the second remote channel's hysteresis.
// - The combined hysteresis register resets to 0x44 and the second remote one to 0x40.
// - Below the start temperature the fan keeps minimum duty until start minus hysteresis.
// - Above the critical limit the output goes to full duty until below limit minus hysteresis.
// - While the lock bit is set, hysteresis, tree-test and offset writes are ignored.
// - Bit 0 of the tree-test register enables tree test mode and resets to zero.
// - The first remote offset register, reset to zero, is added to that channel's reading.
// - The local offset register, reset to zero, is added to the local reading.
// - The second remote offset register, reset to zero, is added to that channel's reading.
// - Bit 1 of the fifth configuration register selects range and resolution of all offsets.
// - Above the start temperature the fan runs at minimum duty plus two steps per degree above start.
// - A critical limit of 0x80 disables forced full duty for that channel.
`timescale 1ns/1ps
module ths_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ths_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ths_pkg::NCH-1:0][7:0] raw_temp,
    input wire logic [ths_pkg::NCH-1:0][7:0] fan_start_temperature,
    input wire logic [ths_pkg::NCH-1:0][7:0] critical_temp_limit,
    input wire logic [ths_pkg::NCH-1:0][7:0] minimum_duty,
    output logic [ths_pkg::NCH-1:0][7:0] corrected_temp,
    output logic [ths_pkg::NCH-1:0][7:0] fan_duty,
    output logic [ths_pkg::NCH-1:0] fan_running,
    output logic [ths_pkg::NCH-1:0] full_duty,
    output logic [ths_pkg::NCH-1:0][3:0] hyst_value,
    output logic tree_test_enable,
    output logic config_lock,
    output logic offset_half_step
);

    logic [7:0] hyst_l_r1_r;
    logic [3:0] remote2_hyst_value_r;
    logic tree_test_r;
    logic [7:0] ofs_r1_r;
    logic [7:0] ofs_l_r;
    logic [7:0] ofs_r2_r;
    logic range_r;
    logic lock_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;

    // Saturate a signed 10-bit sum into an unsigned byte
    function automatic logic [7:0] ths_sat8(input logic [9:0] v);
        if (v[9]) begin
            return 8'h00;
        end else if (v[8]) begin
            return 8'hFF;
        end
        return v[7:0];
    endfunction : ths_sat8

    // Address decode
    wire [9:0] idx = paddr[ths_pkg::ADDR_W-1:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire hit_h01 = aligned && (idx == ths_pkg::IDX_HYST_L_R1);
    wire hit_h2 = aligned && (idx == ths_pkg::IDX_HYST_R2);
    wire hit_tt = aligned && (idx == ths_pkg::IDX_TREE_TEST);
    wire hit_o1 = aligned && (idx == ths_pkg::IDX_OFS_R1);
    wire hit_ol = aligned && (idx == ths_pkg::IDX_OFS_L);
    wire hit_o2 = aligned && (idx == ths_pkg::IDX_OFS_R2);
    wire hit_c5 = aligned && (idx == ths_pkg::IDX_CONFIG5);
    wire hit_lk = aligned && (idx == ths_pkg::IDX_LOCK);
    wire hit_any = hit_h01 | hit_h2 | hit_tt | hit_o1 | hit_ol | hit_o2 | hit_c5 | hit_lk;

    // Setup cycle is answered at the next edge; the write commits on the access edge
    wire setup = psel & ~penable;
    wire commit = psel & penable & pwrite & pready_r & hit_any & pstrb[0];
    // Locked writes still complete on the bus, they simply leave contents alone
    wire wr_ok = commit & ~lock_r;

    wire [7:0] hyst_l_r1_nxt = (wr_ok && hit_h01) ? pwdata[7:0] : hyst_l_r1_r;
    wire [3:0] remote2_hyst_nxt = (wr_ok && hit_h2) ?
        pwdata[ths_pkg::REMOTE2_HYST_LSB +: 4] : remote2_hyst_value_r;
    // Reserved tree-test bits are not stored, so a stray write cannot reach anything
    wire tree_test_nxt = (wr_ok && hit_tt) ? pwdata[ths_pkg::TREE_TEST_BIT] : tree_test_r;
    wire [7:0] ofs_r1_nxt = (wr_ok && hit_o1) ? pwdata[7:0] : ofs_r1_r;
    wire [7:0] ofs_l_nxt = (wr_ok && hit_ol) ? pwdata[7:0] : ofs_l_r;
    wire [7:0] ofs_r2_nxt = (wr_ok && hit_o2) ? pwdata[7:0] : ofs_r2_r;
    wire range_nxt = (wr_ok && hit_c5) ? pwdata[ths_pkg::OFFSET_RANGE_BIT] : range_r;
    // Lock is set-only until reset, so software cannot unlock a frozen configuration
    wire lock_nxt = lock_r | (commit & hit_lk & pwdata[ths_pkg::LOCK_BIT]);

    wire [7:0] rd_byte =
        hit_h01 ? hyst_l_r1_r :
        hit_h2 ? {remote2_hyst_value_r, 4'h0} :
        hit_tt ? {7'h00, tree_test_r} :
        hit_o1 ? ofs_r1_r :
        hit_ol ? ofs_l_r :
        hit_o2 ? ofs_r2_r :
        hit_c5 ? {6'h00, range_r, 1'b0} :
        hit_lk ? {7'h00, lock_r} : 8'h00;

    wire pready_nxt = setup & ~pready_r;
    wire pslverr_nxt = setup & ~pready_r & ~hit_any;
    wire [31:0] prdata_nxt = (setup && !pready_r && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hyst_l_r1_r <= ths_pkg::RST_HYST_L_R1;
            remote2_hyst_value_r <= ths_pkg::RST_HYST_R2[ths_pkg::REMOTE2_HYST_LSB +: 4];
            tree_test_r <= ths_pkg::RST_TREE_TEST[ths_pkg::TREE_TEST_BIT];
            ofs_r1_r <= ths_pkg::RST_OFFSET;
            ofs_l_r <= ths_pkg::RST_OFFSET;
            ofs_r2_r <= ths_pkg::RST_OFFSET;
            range_r <= 1'b0;
            lock_r <= 1'b0;
        end else begin
            hyst_l_r1_r <= hyst_l_r1_nxt;
            remote2_hyst_value_r <= remote2_hyst_nxt;
            tree_test_r <= tree_test_nxt;
            ofs_r1_r <= ofs_r1_nxt;
            ofs_l_r <= ofs_l_nxt;
            ofs_r2_r <= ofs_r2_nxt;
            range_r <= range_nxt;
            lock_r <= lock_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;
    assign tree_test_enable = tree_test_r;
    assign config_lock = lock_r;
    assign offset_half_step = range_r;

    // Channel views of the register contents
    wire [ths_pkg::NCH-1:0][3:0] hyst_all = {
        remote2_hyst_value_r,
        hyst_l_r1_r[ths_pkg::REMOTE1_HYST_LSB +: 4],
        hyst_l_r1_r[ths_pkg::LOCAL_HYST_LSB +: 4]
    };
    wire [ths_pkg::NCH-1:0][7:0] ofs_all = {ofs_r2_r, ofs_r1_r, ofs_l_r};
    assign hyst_value = hyst_all;

    logic [ths_pkg::NCH-1:0][7:0] corr_r;
    logic [ths_pkg::NCH-1:0][7:0] duty_r;
    logic [ths_pkg::NCH-1:0] running_r;
    logic [ths_pkg::NCH-1:0] full_r;

    genvar ch;
    generate
        for (ch = 0; ch < ths_pkg::NCH; ch++) begin : g_chan
            wire [7:0] o = ofs_all[ch];
            // Half-step mode halves the offset weight: finer steps, half the reach
            wire [9:0] ofs_eff = range_r ? {{3{o[7]}}, o[7:1]} : {{2{o[7]}}, o};
            wire [9:0] sum = {2'b00, raw_temp[ch]} + ofs_eff;
            wire [7:0] corr = ths_sat8(sum);
            wire [9:0] t10 = {2'b00, corr};
            wire [9:0] hy10 = {6'h00, hyst_all[ch]};
            wire [9:0] start10 = {2'b00, fan_start_temperature[ch]};
            wire [9:0] crit10 = {2'b00, critical_temp_limit[ch]};
            wire above_start = $signed(t10) > $signed(start10);
            wire at_stop = $signed(t10) <= $signed(start10 - hy10);
            wire crit_off = (critical_temp_limit[ch] == ths_pkg::CRIT_DISABLE);
            wire over_crit = $signed(t10) > $signed(crit10);
            wire below_release = $signed(t10) < $signed(crit10 - hy10);
            wire running_nxt = above_start ? 1'b1 : (at_stop ? 1'b0 : running_r[ch]);
            wire full_nxt = crit_off ? 1'b0 :
                (over_crit ? 1'b1 : (below_release ? 1'b0 : full_r[ch]));
            wire [7:0] delta = corr - fan_start_temperature[ch];
            wire [9:0] ramp = {2'b00, minimum_duty[ch]} +
                10'({2'b00, delta} << ths_pkg::DUTY_SLOPE_SHIFT);
            // Ramp above start, plain minimum duty in the hysteresis band
            // Ramp is unsigned and can pass 511, so clip on its top bits, not as a signed sum
            wire [7:0] ramp_sat = (|ramp[9:8]) ? ths_pkg::DUTY_FULL : ramp[7:0];
            wire [7:0] run_duty = above_start ? ramp_sat : minimum_duty[ch];
            wire [7:0] duty_nxt = full_nxt ? ths_pkg::DUTY_FULL :
                (running_nxt ? run_duty : ths_pkg::DUTY_OFF);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    corr_r[ch] <= 8'h00;
                    duty_r[ch] <= ths_pkg::DUTY_OFF;
                    running_r[ch] <= 1'b0;
                    full_r[ch] <= 1'b0;
                end else begin
                    corr_r[ch] <= corr;
                    duty_r[ch] <= duty_nxt;
                    running_r[ch] <= running_nxt;
                    full_r[ch] <= full_nxt;
                end
            end
        end
    endgenerate

    assign corrected_temp = corr_r;
    assign fan_duty = duty_r;
    assign fan_running = running_r;
    assign full_duty = full_r;

endmodule : ths_regs

// ### shared/ths_pkg.sv
// Constants for the thermal hysteresis and offset register bank.
// Assumes an APB master with 32-bit data; each register index sits at byte address 4*index.
package ths_pkg;

    localparam int ADDR_W = 12;
    localparam int NCH = 3;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_HYST_L_R1 = 10'h06D;
    localparam logic [9:0] IDX_HYST_R2 = 10'h06E;
    localparam logic [9:0] IDX_TREE_TEST = 10'h06F;
    localparam logic [9:0] IDX_OFS_R1 = 10'h070;
    localparam logic [9:0] IDX_OFS_L = 10'h071;
    localparam logic [9:0] IDX_OFS_R2 = 10'h072;
    localparam logic [9:0] IDX_CONFIG5 = 10'h07C;
    localparam logic [9:0] IDX_LOCK = 10'h040;

    // Field positions
    localparam int LOCAL_HYST_LSB = 0;
    localparam int REMOTE1_HYST_LSB = 4;
    localparam int REMOTE2_HYST_LSB = 4;
    localparam int TREE_TEST_BIT = 0;
    localparam int OFFSET_RANGE_BIT = 1;
    localparam int LOCK_BIT = 0;

    // Reset values
    localparam logic [7:0] RST_HYST_L_R1 = 8'h44;
    localparam logic [7:0] RST_HYST_R2 = 8'h40;
    localparam logic [7:0] RST_TREE_TEST = 8'h00;
    localparam logic [7:0] RST_OFFSET = 8'h00;

    // Fan control constants
    localparam logic [7:0] CRIT_DISABLE = 8'h80;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam int DUTY_SLOPE_SHIFT = 1;

    // Channel order on all packed channel ports
    typedef enum logic [1:0] {
        THS_CH_LOCAL,
        THS_CH_REMOTE1,
        THS_CH_REMOTE2
    } ths_channel_type;

endpackage : ths_pkg

// ### test/ths_regs_props.sv
// Port-level checker for the hysteresis and offset register bank.
// Assumes zero-wait APB on pclk; attached by the bind after the module.
`timescale 1ns/1ps
module ths_regs_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0][7:0] critical_temp_limit,
    input wire logic [2:0][7:0] fan_duty,
    input wire logic [2:0] full_duty,
    input wire logic [2:0][3:0] hyst_value,
    input wire logic tree_test_enable,
    input wire logic config_lock,
    input wire logic offset_half_step
);
    wire wr_ok = psel && penable && pready && pwrite && pstrb[0] && !config_lock;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable && !pready |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("pready too long");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_hyst_pair: assert property (wr_ok && paddr == 12'h1B4 |=>
        hyst_value[0] == $past(pwdata[3:0]) && hyst_value[1] == $past(pwdata[7:4]))
        else $error("combined hysteresis not applied");
    a_hyst_remote2: assert property (wr_ok && paddr == 12'h1B8 |=>
        hyst_value[2] == $past(pwdata[7:4])) else $error("remote2 hysteresis not applied");
    a_tree_bit: assert property (wr_ok && paddr == 12'h1BC |=>
        tree_test_enable == $past(pwdata[0])) else $error("tree test bit wrong");
    a_lock_freeze: assert property (config_lock |=> $stable(hyst_value) &&
        $stable(tree_test_enable) && $stable(offset_half_step)) else $error("locked reg changed");
    a_full_means_ff: assert property (full_duty[0] |-> fan_duty[0] == 8'hFF)
        else $error("full duty not 0xFF");
    a_crit_off: assert property (critical_temp_limit[0] == 8'h80 |=> !full_duty[0])
        else $error("disabled limit forced full duty");
    cover property (wr_ok && paddr == 12'h1B4);
    cover property (full_duty[0]);
    cover property (config_lock && psel && penable && pwrite);
endmodule : ths_regs_props

bind ths_regs ths_regs_props u_ths_regs_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .critical_temp_limit(critical_temp_limit),
    .fan_duty(fan_duty), .full_duty(full_duty), .hyst_value(hyst_value),
    .tree_test_enable(tree_test_enable), .config_lock(config_lock),
    .offset_half_step(offset_half_step));

// ### test/tb_ths_regs.sv
// Self-checking bench for the register bank and its fan loop.
// Assumes zero-wait APB slave; bench is the only APB master.
`timescale 1ns/1ps
module tb_ths_regs;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tree_test_enable, config_lock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, seed;
    logic [3:0] pstrb;
    logic [2:0][7:0] raw_temp, fan_start_temperature, critical_temp_limit, minimum_duty;
    logic [2:0][7:0] corrected_temp, fan_duty;
    logic [2:0] fan_running, full_duty;
    logic [2:0][3:0] hyst_value;
    logic offset_half_step, e;
    logic [7:0] d, t;
    int error_cnt = 0, tests_run = 0;
    int chmap[3] = '{1, 0, 2};
    logic [7:0] rstv[6] = '{8'h44, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] temps[7] = '{8'd60, 8'd49, 8'd47, 8'd46, 8'd71, 8'd66, 8'd65};
    logic [6:0] run_e = 7'b1110111, full_e = 7'b0000110;
    ths_regs u_ths_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .raw_temp(raw_temp),
        .fan_start_temperature(fan_start_temperature), .critical_temp_limit(critical_temp_limit),
        .minimum_duty(minimum_duty), .corrected_temp(corrected_temp), .fan_duty(fan_duty),
        .fan_running(fan_running), .full_duty(full_duty), .hyst_value(hyst_value),
        .tree_test_enable(tree_test_enable), .config_lock(config_lock),
        .offset_half_step(offset_half_step));
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] corr(input logic [7:0] raw, input logic [7:0] o, input int h);
        int s;
        s = int'(raw) + (h ? int'($signed(o) >>> 1) : int'($signed(o)));
        return (s < 0) ? 8'h00 : (s > 255) ? 8'hFF : s[7:0];
    endfunction : corr
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) error_cnt++;
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, raw_temp} = '0;
        pstrb = 4'hF;
        seed = 32'hA550;
        fan_start_temperature = {3{8'hC8}};
        critical_temp_limit = {3{8'h80}};
        minimum_duty = {3{8'h40}};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(0, 12'h1B4 + 12'(4 * i), 8'h00);
            chk("reset value", r, rstv[i]);
        end
        chk("reset hyst", hyst_value, 12'h444);
        repeat (4) begin
            seed = lfsr(seed);
            // Keep each hysteresis nibble at four degrees or more
            d = seed[7:0] | {1'b0, ~|seed[7:6], 2'b00, 1'b0, ~|seed[3:2], 2'b00};
            apb(1, 12'h1B4, d);
            apb(1, 12'h1B8, d);
            apb(1, 12'h1BC, {7'h00, d[0]});
            apb(0, 12'h1B8, 8'h00);
            chk("remote2 hyst reg", r, {d[7:4], 4'h0});
            chk("hyst out", hyst_value, {d[7:4], d[7:4], d[3:0]});
            chk("tree test", tree_test_enable, d[0]);
        end
        for (int h = 0; h < 2; h++) for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            apb(1, 12'h1F0, {6'h00, h[0], 1'b0});
            apb(1, 12'h1C0 + 12'(4 * i), seed[7:0]);
            raw_temp[chmap[i]] <= seed[15:8];
            repeat (3) @(posedge pclk);
            chk("range sel", offset_half_step, h[0]);
            chk("corrected", corrected_temp[chmap[i]], corr(seed[15:8], seed[7:0], h));
        end
        apb(1, 12'h1C4, 8'h00);
        apb(1, 12'h1B4, 8'h44);
        fan_start_temperature[0] <= 8'd50;
        for (int k = 0; k < 7; k++) begin
            t = temps[k];
            if (k == 4) critical_temp_limit[0] <= 8'd70;
            raw_temp[0] <= t;
            repeat (4) @(posedge pclk);
            chk("running", fan_running[0], run_e[6 - k]);
            chk("full", full_duty[0], full_e[6 - k]);
            chk("duty", fan_duty[0], full_e[6 - k] ? 8'hFF : !run_e[6 - k] ? 8'h00 :
                (t > 50) ? 8'h40 + 2 * (t - 8'd50) : 8'h40);
        end
        critical_temp_limit[0] <= 8'h80;
        minimum_duty[0] <= 8'hC0;
        raw_temp[0] <= 8'd255;
        repeat (4) @(posedge pclk);
        chk("limit disabled", full_duty[0], 1'b0);
        chk("duty clip", fan_duty[0], 8'hFF);
        pstrb <= 4'hE;
        apb(1, 12'h1C4, 8'h55);
        pstrb <= 4'hF;
        apb(0, 12'h1C4, 8'h00);
        chk("no strobe", r, 32'h0);
        apb(0, 12'h004, 8'h00);
        chk("unmapped err", e, 1'b1);
        chk("unmapped data", r, 32'h0);
        apb(0, 12'h1B6, 8'h00);
        chk("misaligned err", e, 1'b1);
        apb(1, 12'h100, 8'h01);
        apb(1, 12'h1B4, 8'h99);
        apb(0, 12'h1B4, 8'h00);
        chk("locked hyst", r, 32'h44);
        chk("lock bit", config_lock, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h1C0, 8'h00);
        chk("offset after reset", r, 32'h0);
        chk("lock after reset", config_lock, 1'b0);
        tally_and_finish();
    end
endmodule : tb_ths_regs
